// [design/sdram_cmd_regs.svh]
// Purpose: Constants for the command decode and power-state block.
// Assumes: Command pins sampled on the block clock after synchronisation.
// Notes: Times are given in memory clock cycles; SELF_REFRESH_INT is in block clock cycles.
`ifndef SDRAM_CMD_REGS_SVH
`define SDRAM_CMD_REGS_SVH
`define BANKS            8
`define BANK_W           3
`define ADDR_W           15
`define ADDR_AP_BIT      10
`define ADDR_BC_BIT      12
`define BURST_FULL       4'h4
`define BURST_CHOP       4'h2
`define EXIT_DELAY       10'h005
`define EXIT_DLL_DELAY   10'h200
`define BUSY_DELAY       10'h004
`define SELF_REFRESH_INT 10'h040
`define MR_FIXED_CHOP    2'h2
`define MR_ON_THE_FLY    2'h1
`endif

// [design/sdram_cmd_pkg.sv]
// Purpose: Types for the command decode and power-state block.
// Assumes: Included constants header.
// Notes: States are one-hot.
package sdram_cmd_pkg;
	typedef enum logic [3:0] {
		CMD_MODE_SET = 4'h0, CMD_REFRESH = 4'h1, CMD_PRECHARGE = 4'h2, CMD_ACTIVATE = 4'h3,
		CMD_WRITE = 4'h4, CMD_READ = 4'h5, CMD_CALIBRATE = 4'h6, CMD_NO_OPERATION = 4'h7,
		CMD_DESELECT = 4'h8
	} command_t;
	typedef enum logic [4:0] {
		ST_IDLE         = 5'h01,
		ST_ACTIVE       = 5'h02,
		ST_ACTIVE_PD    = 5'h04,
		ST_PRECHARGE_PD = 5'h08,
		ST_SELF_REFRESH = 5'h10
	} power_state_t;
	typedef struct packed {
		logic        chip_select_b;
		logic        row_strobe_b;
		logic        column_strobe_b;
		logic        write_enable_b;
		logic        clock_enable;
		logic [2:0]  bank;
		logic [14:0] addr;
	} cmd_pins_t;
	typedef struct packed {
		command_t   cmd;
		logic [2:0] bank;
		logic       auto_precharge;
		logic       chop;
	} decoded_t;
endpackage

// [design/bank_state_mem.sv]
// Purpose: Small per-bank open flag store with registered read.
// Assumes: One write and one read port on the block clock.
// Notes: All flags clear on reset.
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"
module bank_state_mem (
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic               set_en,
	input  wire logic               clear_en,
	input  wire logic               clear_all,
	input  wire logic [`BANK_W-1:0] bank,
	output logic      [`BANKS-1:0]  open_q
);
	genvar gi;
	generate
		for (gi = 0; gi < `BANKS; gi++) begin : g_bank
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					open_q[gi] <= 1'b0;
				end else if (set_en && int'(bank) == gi) begin
					open_q[gi] <= 1'b1;
				end else if (clear_all || (clear_en && int'(bank) == gi)) begin
					open_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule // bank_state_mem

// [design/sdram_cmd_decode.sv]
// Purpose: Command decode and clock-enable power-state logic of the memory.
// Assumes: Memory clock arrives as a pin and is sampled by the block clock.
// Notes: Pins are synchronised through two flops before use.
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"
module sdram_cmd_decode
	import sdram_cmd_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          mem_clock,
	input  wire cmd_pins_t     pins,
	input  wire logic          on_die_termination,
	input  wire logic [1:0]    burst_mode,
	output decoded_t           cmd_q,
	output logic               cmd_valid_q,
	output logic               mode_write_q,
	output logic [2:0]         mode_select_q,
	output power_state_t       state_q,
	output logic               burst_busy_q,
	output logic               refresh_pulse_q,
	output logic               termination_on_q,
	output logic               write_allowed_q,
	output logic               read_allowed_q,
	output logic               idle_q,
	output logic [`BANKS-1:0]  bank_open_q
);
	cmd_pins_t    pins_s1_q, pins_s2_q;
	logic [2:0]   mclk_q;
	logic         odt_s1_q, odt_s2_q;
	logic         cke_prev_q;
	logic         edge_w;
	decoded_t     dec_w;
	logic         sel_w;
	logic [3:0]   burst_cnt_q;
	logic [9:0]   wait_cnt_q;
	logic [9:0]   dll_cnt_q;
	logic [9:0]   sr_cnt_q;
	logic [`BANKS-1:0] open_w;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			mclk_q    <= 3'h0;
			odt_s1_q  <= 1'b0;
			odt_s2_q  <= 1'b0;
		end else begin
			pins_s1_q <= pins;
			pins_s2_q <= pins_s1_q;
			mclk_q    <= {mclk_q[1:0], mem_clock};
			odt_s1_q  <= on_die_termination;
			odt_s2_q  <= odt_s1_q;
		end
	end

	// Rising edge of the memory clock, seen after two sync flops.
	assign edge_w = mclk_q[1] && !mclk_q[2];

	always_comb begin
		dec_w.bank           = pins_s2_q.bank;
		dec_w.auto_precharge = pins_s2_q.addr[`ADDR_AP_BIT];
		dec_w.chop           = (burst_mode == `MR_ON_THE_FLY) ? !pins_s2_q.addr[`ADDR_BC_BIT] :
			(burst_mode == `MR_FIXED_CHOP);
		if (pins_s2_q.chip_select_b) begin
			dec_w.cmd = CMD_DESELECT;
		end else begin
			dec_w.cmd = command_t'({1'b0, pins_s2_q.row_strobe_b, pins_s2_q.column_strobe_b,
				pins_s2_q.write_enable_b});
		end
	end

	// Command is only acted upon with enable high on both edges and not in power saving.
	assign sel_w = edge_w && cke_prev_q && pins_s2_q.clock_enable &&
		(state_q == ST_IDLE || state_q == ST_ACTIVE);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cke_prev_q <= 1'b0;
		end else if (edge_w) begin
			cke_prev_q <= pins_s2_q.clock_enable;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q         <= '{cmd: CMD_DESELECT, bank: 3'h0, auto_precharge: 1'b0, chop: 1'b0};
			cmd_valid_q   <= 1'b0;
			mode_write_q  <= 1'b0;
			mode_select_q <= 3'h0;
		end else begin
			// No-operation and deselect register nothing new.
			cmd_valid_q  <= sel_w && dec_w.cmd != CMD_NO_OPERATION && dec_w.cmd != CMD_DESELECT;
			mode_write_q <= sel_w && dec_w.cmd == CMD_MODE_SET;
			if (sel_w && dec_w.cmd != CMD_NO_OPERATION && dec_w.cmd != CMD_DESELECT) begin
				cmd_q <= dec_w;
			end
			if (sel_w && dec_w.cmd == CMD_MODE_SET) begin
				mode_select_q <= dec_w.bank;
			end
		end
	end

	bank_state_mem u_banks (
		.clock     (clock),
		.rst_b     (rst_b),
		.set_en    (sel_w && dec_w.cmd == CMD_ACTIVATE),
		.clear_en  (sel_w && ((dec_w.cmd == CMD_PRECHARGE) ||
			((dec_w.cmd == CMD_READ || dec_w.cmd == CMD_WRITE) && dec_w.auto_precharge))),
		.clear_all (sel_w && dec_w.cmd == CMD_PRECHARGE && dec_w.auto_precharge),
		.bank      (dec_w.bank),
		.open_q    (open_w)
	);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bank_open_q <= '0;
		end else begin
			bank_open_q <= open_w;
		end
	end

	// Burst counter in memory clock edges; nothing aborts it once started.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			burst_cnt_q <= 4'h0;
		end else if (sel_w && (dec_w.cmd == CMD_READ || dec_w.cmd == CMD_WRITE) && burst_cnt_q == 4'h0) begin
			burst_cnt_q <= dec_w.chop ? `BURST_CHOP : `BURST_FULL;
		end else if (edge_w && burst_cnt_q != 4'h0) begin
			burst_cnt_q <= burst_cnt_q - 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			burst_busy_q <= 1'b0;
		end else begin
			burst_busy_q <= burst_cnt_q != 4'h0;
		end
	end

	// Power-state machine.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
		end else if (edge_w) begin
			case (state_q)
				ST_IDLE, ST_ACTIVE: begin
					if (cke_prev_q && !pins_s2_q.clock_enable) begin
						// Idle is judged without the enable term, which is already falling here.
						if (state_q == ST_IDLE && open_w == '0 && burst_cnt_q == 4'h0 && wait_cnt_q == 10'h000 &&
							dll_cnt_q == 10'h000 && dec_w.cmd == CMD_REFRESH) begin
							state_q <= ST_SELF_REFRESH;
						end else if (open_w == '0) begin
							state_q <= ST_PRECHARGE_PD;
						end else begin
							state_q <= ST_ACTIVE_PD;
						end
					end else if (open_w != '0) begin
						state_q <= ST_ACTIVE;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_ACTIVE_PD: begin
					if (pins_s2_q.clock_enable) begin
						state_q <= ST_ACTIVE;
					end
				end
				ST_PRECHARGE_PD: begin
					if (pins_s2_q.clock_enable) begin
						state_q <= ST_IDLE;
					end
				end
				ST_SELF_REFRESH: begin
					state_q <= ST_SELF_REFRESH;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end else if (state_q == ST_SELF_REFRESH && pins_s2_q.clock_enable) begin
			state_q <= ST_IDLE;
		end
	end

	// Exit delay counters, counted in memory clock edges.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt_q <= 10'h000;
			dll_cnt_q  <= 10'h000;
		end else if (state_q == ST_SELF_REFRESH && pins_s2_q.clock_enable) begin
			wait_cnt_q <= `EXIT_DELAY;
			dll_cnt_q  <= `EXIT_DLL_DELAY;
		end else if (edge_w && (state_q == ST_ACTIVE_PD || state_q == ST_PRECHARGE_PD) &&
			pins_s2_q.clock_enable) begin
			wait_cnt_q <= `BUSY_DELAY;
		end else if (edge_w) begin
			if (wait_cnt_q != 10'h000) begin
				wait_cnt_q <= wait_cnt_q - 10'h001;
			end
			if (dll_cnt_q != 10'h000) begin
				dll_cnt_q <= dll_cnt_q - 10'h001;
			end
		end
	end

	// Internal refresh only while in self refresh; never in power-down.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sr_cnt_q        <= 10'h000;
			refresh_pulse_q <= 1'b0;
		end else if (state_q == ST_SELF_REFRESH) begin
			refresh_pulse_q <= sr_cnt_q == `SELF_REFRESH_INT;
			sr_cnt_q        <= (sr_cnt_q == `SELF_REFRESH_INT) ? 10'h000 : sr_cnt_q + 10'h001;
		end else begin
			sr_cnt_q        <= 10'h000;
			refresh_pulse_q <= sel_w && dec_w.cmd == CMD_REFRESH && pins_s2_q.clock_enable;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			termination_on_q <= 1'b0;
			write_allowed_q  <= 1'b0;
			read_allowed_q   <= 1'b0;
			idle_q           <= 1'b0;
		end else begin
			termination_on_q <= odt_s2_q && state_q != ST_SELF_REFRESH;
			write_allowed_q  <= dll_cnt_q == 10'h000 && wait_cnt_q == 10'h000 && state_q != ST_SELF_REFRESH;
			read_allowed_q   <= dll_cnt_q == 10'h000 && wait_cnt_q == 10'h000 && state_q != ST_SELF_REFRESH;
			idle_q           <= open_w == '0 && burst_cnt_q == 4'h0 && pins_s2_q.clock_enable &&
				wait_cnt_q == 10'h000 && dll_cnt_q == 10'h000 && state_q == ST_IDLE;
		end
	end
endmodule // sdram_cmd_decode

// [verif/sdram_cmd_decode_asserts.sv]
// Purpose: Concurrent checks on the command decode ports.
// Assumes: Bound to sdram_cmd_decode from the bench top.
// Notes: One clock domain; reset disables every check.
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"
module sdram_cmd_decode_asserts
	import sdram_cmd_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst_b,
	input wire cmd_pins_t         pins,
	input wire decoded_t          cmd_q,
	input wire logic              cmd_valid_q,
	input wire logic              mode_write_q,
	input wire logic [2:0]        mode_select_q,
	input wire power_state_t      state_q,
	input wire logic              burst_busy_q,
	input wire logic              refresh_pulse_q,
	input wire logic              termination_on_q,
	input wire logic              idle_q,
	input wire logic [`BANKS-1:0] bank_open_q
);
	logic [7:0] sr_gap_q;
	logic       pd_any;
	logic       pd_only;
	assign pd_any  = state_q inside {ST_ACTIVE_PD, ST_PRECHARGE_PD, ST_SELF_REFRESH};
	assign pd_only = state_q inside {ST_ACTIVE_PD, ST_PRECHARGE_PD};
	// Counts cycles in self refresh since the last refresh pulse.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			sr_gap_q <= 8'h00;
		else if (state_q != ST_SELF_REFRESH || refresh_pulse_q)
			sr_gap_q <= 8'h00;
		else
			sr_gap_q <= sr_gap_q + 8'h01;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	valid_kind_a: assert property (cmd_valid_q |->
		!(cmd_q.cmd inside {CMD_NO_OPERATION, CMD_DESELECT})) else $error("pulse for idle command");
	mode_sel_a: assert property (mode_write_q |->
		cmd_q.cmd == CMD_MODE_SET && mode_select_q == cmd_q.bank) else $error("mode select wrong");
	pd_ignore_a: assert property (pd_any && $past(pd_any) |-> !cmd_valid_q)
		else $error("command taken in low power");
	pd_no_ref_a: assert property (pd_only && $past(pd_only) |-> !refresh_pulse_q)
		else $error("refresh in power down");
	term_off_a: assert property (state_q == ST_SELF_REFRESH && $past(state_q) == ST_SELF_REFRESH
		|-> !termination_on_q) else $error("termination on in self refresh");
	sr_tick_a: assert property (sr_gap_q < 8'h50) else $error("no internal refresh");
	idle_def_a: assert property (idle_q |-> state_q == ST_IDLE && bank_open_q == '0
		&& !burst_busy_q) else $error("idle with work pending");
	sr_exit_a: assert property ((state_q == ST_SELF_REFRESH && pins.clock_enable) [*3]
		|-> ##[0:4] state_q != ST_SELF_REFRESH) else $error("self refresh exit late");
	sr_entry_a: assert property ($rose(state_q == ST_SELF_REFRESH) |-> $past(state_q) == ST_IDLE)
		else $error("self refresh entered from busy state");
	cov_read_c: cover property (cmd_valid_q && cmd_q.cmd == CMD_READ);
	cov_apd_c: cover property (state_q == ST_ACTIVE_PD);
	cov_sr_c: cover property (state_q == ST_SELF_REFRESH && refresh_pulse_q);
endmodule // sdram_cmd_decode_asserts

// [verif/mem_ctrl_model.sv]
// Purpose: Controller model driving the memory clock and command pins.
// Assumes: Pins change only on the falling memory clock edge.
// Notes: Between commands the device is deselected with inverted pins.
`timescale 1ns/1ps
module mem_ctrl_model
	import sdram_cmd_pkg::*;
(
	output logic      mem_clock,
	output cmd_pins_t pins
);
	cmd_pins_t cur;
	initial begin
		mem_clock = 1'b0;
		cur = '0;
		cur.chip_select_b = 1'b1;
		cur.clock_enable = 1'b1;
		pins = cur;
	end
	always #40 mem_clock = ~mem_clock;
	always @(negedge mem_clock) pins <= cur;
	// Presents one command for one edge, then deselects while keeping clock enable.
	task automatic send(input command_t c, input logic cke, input logic [2:0] ba, input logic [14:0] a);
		@(posedge mem_clock);
		cur = {c[3], c[2:0], cke, ba, a};
		@(posedge mem_clock);
		cur = {1'b1, ~cur.row_strobe_b, ~cur.column_strobe_b, ~cur.write_enable_b, cke, ~ba, ~a};
	endtask
endmodule // mem_ctrl_model

// [verif/sdram_command_and_power_state_decode_tb_top.sv]
// Purpose: Self-checking bench for the command decode and power-state block.
// Assumes: Controller model drives the memory clock and pins.
// Notes: Banks, addresses and termination are random from a fixed seed.
`timescale 1ns/1ps
`include "sdram_cmd_regs.svh"
`define check_eq(e, s, n) begin check_count++; if ((s) !== (e)) begin bad_count++; \
	$display("unexpected %s: expected %h seen %h", n, e, s); end end
module sdram_command_and_power_state_decode_tb_top
	import sdram_cmd_pkg::*;
;
	logic clock, rst_b, mem_clock, on_die_termination, got;
	logic cmd_valid_q, mode_write_q, burst_busy_q, refresh_pulse_q;
	logic termination_on_q, write_allowed_q, read_allowed_q, idle_q;
	logic [1:0] burst_mode;
	logic [2:0] mode_select_q, ba;
	logic [14:0] ad;
	logic [`BANKS-1:0] bank_open_q;
	cmd_pins_t pins;
	decoded_t cmd_q;
	power_state_t state_q;
	int bad_count, check_count, n;
	command_t seq[9] = '{CMD_MODE_SET, CMD_REFRESH, CMD_CALIBRATE, CMD_NO_OPERATION,
		CMD_DESELECT, CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_PRECHARGE};
	mem_ctrl_model ctl (.mem_clock(mem_clock), .pins(pins));
	sdram_cmd_decode uut (.clock(clock), .rst_b(rst_b), .mem_clock(mem_clock), .pins(pins),
		.on_die_termination(on_die_termination), .burst_mode(burst_mode), .cmd_q(cmd_q),
		.cmd_valid_q(cmd_valid_q), .mode_write_q(mode_write_q), .mode_select_q(mode_select_q),
		.state_q(state_q), .burst_busy_q(burst_busy_q), .refresh_pulse_q(refresh_pulse_q),
		.termination_on_q(termination_on_q), .write_allowed_q(write_allowed_q),
		.read_allowed_q(read_allowed_q), .idle_q(idle_q), .bank_open_q(bank_open_q));
	initial clock = 1'b0;
	always #4 clock = ~clock;
	function automatic logic exp_chop(input logic [1:0] m, input logic a12);
		return (m == 2'h1) ? !a12 : (m == 2'h2);
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Sends one command and checks the decoded result when a pulse is seen.
	task automatic run(input command_t c, input logic cke, input logic exp);
		@(posedge clock);
		on_die_termination <= 1'($urandom_range(1, 0));
		ba = 3'($urandom);
		ad = 15'($urandom);
		if (c == CMD_PRECHARGE)
			ad[`ADDR_AP_BIT] = 1'b1;
		ctl.send(c, cke, ba, ad);
		got = 1'b0;
		for (int i = 0; i < 10 && !got; i++) begin
			@(posedge clock);
			#1 got = (cmd_valid_q === 1'b1);
		end
		if (exp !== 1'bx)
			`check_eq(exp, got, "valid")
		if (got) begin
			`check_eq(c, cmd_q.cmd, "cmd")
			`check_eq(ba, cmd_q.bank, "bank")
			if (c inside {CMD_READ, CMD_WRITE}) begin
				`check_eq(ad[`ADDR_AP_BIT], cmd_q.auto_precharge, "auto")
				`check_eq(exp_chop(burst_mode, ad[`ADDR_BC_BIT]), cmd_q.chop, "chop")
			end
			if (c == CMD_MODE_SET)
				`check_eq(ba, mode_select_q, "mode sel")
			if (c == CMD_ACTIVATE) begin
				repeat (3) @(posedge clock);
				`check_eq(1'b1, bank_open_q[ba], "open")
			end
		end
	endtask
	task automatic wait_state(input power_state_t s);
		for (n = 0; n < 100 && state_q !== s; n++) begin
			@(posedge clock);
			#1;
		end
		`check_eq(s, state_q, "state")
		if (state_q !== s)
			give_verdict();
	endtask
	initial begin
		void'($urandom(32'ha846));
		rst_b = 1'b0;
		burst_mode = 2'h1;
		on_die_termination = 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) ctl.send(CMD_DESELECT, 1'b1, 3'h0, 15'h0);
		foreach (seq[i])
			run(seq[i], 1'b1, !(seq[i] inside {CMD_NO_OPERATION, CMD_DESELECT}));
		for (int m = 0; m < 3; m++) begin
			@(posedge clock);
			burst_mode <= 2'(m);
			run(CMD_ACTIVATE, 1'b1, 1'b1);
			run(CMD_WRITE, 1'b1, 1'b1);
			run(CMD_NO_OPERATION, 1'b1, 1'b0);
			run(CMD_PRECHARGE, 1'b1, 1'b1);
		end
		run(CMD_ACTIVATE, 1'b1, 1'b1);
		run(CMD_NO_OPERATION, 1'b0, 1'b0);
		wait_state(ST_ACTIVE_PD);
		run(CMD_READ, 1'b0, 1'b0);
		run(CMD_NO_OPERATION, 1'b1, 1'b0);
		wait_state(ST_ACTIVE);
		run(CMD_PRECHARGE, 1'b1, 1'b1);
		wait_state(ST_IDLE);
		run(CMD_NO_OPERATION, 1'b0, 1'b0);
		wait_state(ST_PRECHARGE_PD);
		run(CMD_NO_OPERATION, 1'b1, 1'b0);
		wait_state(ST_IDLE);
		for (n = 0; n < 100 && idle_q !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		`check_eq(1'b1, idle_q, "idle")
		run(CMD_REFRESH, 1'b0, 1'bx);
		wait_state(ST_SELF_REFRESH);
		@(posedge clock);
		on_die_termination <= 1'b1;
		repeat (200) @(posedge clock);
		`check_eq(1'b0, termination_on_q, "termination")
		run(CMD_NO_OPERATION, 1'b1, 1'b0);
		wait_state(ST_IDLE);
		`check_eq(2'b00, {write_allowed_q, read_allowed_q}, "allowed early")
		for (n = 0; n < 700 && write_allowed_q !== 1'b1; n++)
			@(posedge mem_clock);
		`check_eq(1'b1, n >= 512 && n <= 513, "exit wait")
		`check_eq(1'b1, read_allowed_q, "read allowed")
		`check_eq(1'b1, termination_on_q, "termination on")
		run(CMD_ACTIVATE, 1'b1, 1'b1);
		run(CMD_WRITE, 1'b1, 1'b1);
		give_verdict();
	end
endmodule // sdram_command_and_power_state_decode_tb_top
bind sdram_cmd_decode sdram_cmd_decode_asserts chk (.clock(clock), .rst_b(rst_b), .pins(pins),
	.cmd_q(cmd_q), .cmd_valid_q(cmd_valid_q), .mode_write_q(mode_write_q), .mode_select_q(mode_select_q),
	.state_q(state_q), .burst_busy_q(burst_busy_q), .refresh_pulse_q(refresh_pulse_q),
	.termination_on_q(termination_on_q), .idle_q(idle_q), .bank_open_q(bank_open_q));
